// file: spirg_pkg.sv
// spirg_pkg: constants, types and field layout of the serial register gate.
// assumes its users: spirg_slave, spirg_asserts, spirg_master_model and tb_spi_slave_register_access.
//
// Function
// R01: master drives clock, select and input data; device drives output only.
// R02: master keeps serial clock low while no transfer runs.
// R03: select low starts a transfer, select high ends and abandons it.
// R04: access is 27 header bits, 5 turnaround bits, then 8 data bits.
// R05: header opens with command 011 read or 010 write, then address.
// R06: turnaround bit values are ignored by the device.
// R07: only the low 16 address bits count; upper eight are ignored.
// R08: burst: select stays low, address advances by one every 8 clocks.
// R09: command, address and data all travel most significant bit first.
// R10: input line is sampled on each rising serial clock edge.
// R11: output line changes on each falling serial clock edge.
// R12: interface mode comes from a strap sampled at reset release.
// R13: the whole register space is reachable for read and write.
// R14: output is driven only in read data phase while selected.

package spirg_pkg;

    // ****************************************************************
    // frame layout
    // ****************************************************************
    localparam int HDR_BITS = 27;
    localparam int TA_BITS = 5;
    localparam int DATA_BITS = 8;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 6;
    localparam logic [5:0] HDR_LAST = 6'h1A;
    localparam logic [5:0] DATA_START = 6'h20;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int CMD_MSB = 26;
    localparam int CMD_LSB = 24;
    localparam logic [2:0] CMD_READ = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h2;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [5:0] CNT_RST = 6'h00;
    localparam logic [2:0] BIT_RST = 3'h0;

    // ****************************************************************
    // management mode strap encoding
    // ****************************************************************
    localparam logic [1:0] STRAP_SPI = 2'h0;
    localparam logic [1:0] STRAP_TWO_WIRE = 2'h1;

    typedef enum logic [1:0] {
        spirg_mode_serial,
        spirg_mode_two_wire,
        spirg_mode_station_management
    } spirg_mode_type;

    // one register access toward the register file, one cycle long
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spirg_req_type;

    localparam spirg_req_type REQ_RST = '{
        addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

endpackage : spirg_pkg

// file: spirg_slave.sv
// spirg_slave: serial slave that gives an outside master byte access to the
// register file. serial side runs on the master's clock, the register side
// on clk_sys; register file answers a read in the cycle of its strobe.
`timescale 1ns/100ps
`default_nettype none

module spirg_slave (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic link_sclk,
    input wire logic chip_select_low,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    input wire logic [1:0] mode_strap,
    output spirg_pkg::spirg_mode_type mgmt_mode,
    output logic link_busy,
    output spirg_pkg::spirg_req_type reg_req,
    input wire logic [7:0] reg_rd_data
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // msb-first byte shift, used for write capture and read output
    function automatic logic [7:0] shift_byte(
        input logic [7:0] cur,
        input logic bit_in
    );
        shift_byte = {cur[6:0], bit_in};
    endfunction : shift_byte

    function automatic spirg_pkg::spirg_mode_type decode_strap(
        input logic [1:0] strap
    );
        case (strap)
            spirg_pkg::STRAP_SPI: begin
                decode_strap = spirg_pkg::spirg_mode_serial;
            end
            spirg_pkg::STRAP_TWO_WIRE: begin
                decode_strap = spirg_pkg::spirg_mode_two_wire;
            end
            default: begin
                decode_strap = spirg_pkg::spirg_mode_station_management;
            end
        endcase
    endfunction : decode_strap

    // a crossed toggle that differs from its last seen copy is one event;
    // toggles are used so a pulse shorter than clk_sys is never missed
    function automatic logic toggle_event(
        input logic synced,
        input logic seen
    );
        toggle_event = synced ^ seen;
    endfunction : toggle_event

    // ****************************************************************
    // link domain: frame tracking, reset by select high
    // ****************************************************************

    logic [5:0] cnt_r;
    logic [2:0] dbit_r;
    logic [25:0] hdr_r;
    logic [26:0] hdr_nxt;
    logic rd_r;
    logic wr_r;
    logic [15:0] addr_r;
    logic [7:0] wsh_r;
    logic in_data;
    logic hdr_done;
    logic [2:0] cmd_nxt;

    assign hdr_nxt = {hdr_r, serial_data_in}; // R09
    assign cmd_nxt = hdr_nxt[spirg_pkg::CMD_MSB:spirg_pkg::CMD_LSB];
    assign hdr_done = (cnt_r == spirg_pkg::HDR_LAST);
    assign in_data = (cnt_r == spirg_pkg::DATA_START);

    // select high clears the frame at once, so a cut frame leaves no half
    // byte behind; the master keeps the clock low while select moves
    // clock is only ever received here, never made
    always_ff @(posedge link_sclk or posedge chip_select_low) begin // R01
        if (chip_select_low) begin // R03
            cnt_r <= spirg_pkg::CNT_RST;
            dbit_r <= spirg_pkg::BIT_RST;
            hdr_r <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= spirg_pkg::ADDR_RST;
            wsh_r <= spirg_pkg::BYTE_RST;
        end else begin
            // header and turnaround bits counted, data phase holds count
            if (!in_data) begin // R04
                cnt_r <= cnt_r + 6'h01;
            end
            if (!in_data) begin
                hdr_r <= hdr_nxt[25:0]; // R10
            end
            // turnaround bits only advance the count, value unused
            if (hdr_done) begin // R06
                rd_r <= (cmd_nxt == spirg_pkg::CMD_READ); // R05
                wr_r <= (cmd_nxt == spirg_pkg::CMD_WRITE); // R05
                addr_r <= hdr_nxt[15:0]; // R07
            end
            if (in_data) begin
                dbit_r <= dbit_r + 3'h1;
                wsh_r <= shift_byte(wsh_r, serial_data_in); // R10
                if (dbit_r == spirg_pkg::BIT_LAST) begin
                    addr_r <= addr_r + 16'h0001; // R08
                end
            end
        end
    end

    // ****************************************************************
    // link domain: requests toward the system side
    // ****************************************************************

    // unknown commands leave both flags low, the frame just runs out
    logic rd_fire;
    logic wr_fire;
    logic [15:0] rd_fire_addr;
    logic rd_tgl_r;
    logic wr_tgl_r;
    logic [15:0] rd_addr_x_r;
    logic [15:0] wr_addr_x_r;
    logic [7:0] wr_data_x_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_tgl_r;

    // header read fetches the first byte, each burst byte prefetches
    // the next so the answer has seven clocks to come back
    assign rd_fire = (hdr_done && cmd_nxt == spirg_pkg::CMD_READ)
        || (in_data && rd_r && dbit_r == spirg_pkg::BIT_RST); // R08
    assign rd_fire_addr = hdr_done ? hdr_nxt[15:0]
        : addr_r + 16'h0001; // R13
    assign wr_fire = in_data && wr_r
        && dbit_r == spirg_pkg::BIT_LAST; // R08

    // toggles must survive select high, so only device reset clears them
    always_ff @(posedge link_sclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_tgl_r <= 1'b0;
            rd_addr_x_r <= spirg_pkg::ADDR_RST;
        end else if (rd_fire) begin
            rd_tgl_r <= ~rd_tgl_r;
            rd_addr_x_r <= rd_fire_addr;
        end
    end

    // handed over at the last data edge only, so a byte cut short by select
    // never reaches the register file
    always_ff @(posedge link_sclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_tgl_r <= 1'b0;
            wr_addr_x_r <= spirg_pkg::ADDR_RST;
            wr_data_x_r <= spirg_pkg::BYTE_RST;
        end else if (wr_fire) begin
            wr_tgl_r <= ~wr_tgl_r;
            wr_addr_x_r <= addr_r; // R13
            wr_data_x_r <= shift_byte(wsh_r, serial_data_in); // R09
        end
    end

    always_ff @(posedge link_sclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // ****************************************************************
    // link domain: read data output on falling edges
    // ****************************************************************

    logic [7:0] sdo_sh_r;
    logic oe_r;
    logic [7:0] rdata_r;
    logic load_byte;
    logic acked;

    assign load_byte = rd_r && in_data && dbit_r == spirg_pkg::BIT_RST;
    // a late answer shows as zero rather than stale data
    // limitation: a link clock far faster than clk_sys reads only zeros
    assign acked = (ack_s2_r == rd_tgl_r);

    always_ff @(negedge link_sclk or posedge chip_select_low) begin
        if (chip_select_low) begin // R03
            sdo_sh_r <= spirg_pkg::BYTE_RST;
            oe_r <= 1'b0;
        end else if (load_byte) begin // R11
            sdo_sh_r <= acked ? rdata_r : spirg_pkg::BYTE_RST;
            oe_r <= 1'b1; // R14
        end else begin
            sdo_sh_r <= shift_byte(sdo_sh_r, 1'b0); // R09
        end
    end

    logic serial_mode;

    assign serial_mode = (mgmt_mode == spirg_pkg::spirg_mode_serial);
    assign serial_data_out = sdo_sh_r[7]; // R11
    assign serial_data_out_oe = oe_r && serial_mode; // R14

    // ****************************************************************
    // system domain: crossing of requests and select
    // ****************************************************************

    logic rd_s1_r;
    logic rd_s2_r;
    logic rd_seen_r;
    logic wr_s1_r;
    logic wr_s2_r;
    logic wr_seen_r;
    logic cs_s1_r;
    logic cs_s2_r;
    logic rd_evt;
    logic wr_evt;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_s1_r <= 1'b0;
            rd_s2_r <= 1'b0;
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
        end else begin
            rd_s1_r <= rd_tgl_r;
            rd_s2_r <= rd_s1_r;
            wr_s1_r <= wr_tgl_r;
            wr_s2_r <= wr_s1_r;
            cs_s1_r <= chip_select_low;
            cs_s2_r <= cs_s1_r;
        end
    end

    // a read and a write landing together: read first, write next cycle
    assign rd_evt = toggle_event(rd_s2_r, rd_seen_r);
    assign wr_evt = toggle_event(wr_s2_r, wr_seen_r) && !rd_evt;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_seen_r <= 1'b0;
            wr_seen_r <= 1'b0;
        end else begin
            rd_seen_r <= rd_s2_r;
            if (!rd_evt) begin
                wr_seen_r <= wr_s2_r;
            end
        end
    end

    assign link_busy = !cs_s2_r;

    // ****************************************************************
    // system domain: register file access
    // ****************************************************************

    spirg_pkg::spirg_req_type req_r;

    // requests are dropped outside serial mode, so the other modes
    // cannot reach the register file through this path
    // addr and wdata follow every event, only the strobes qualify them
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            req_r <= spirg_pkg::REQ_RST;
        end else begin
            req_r.rd <= rd_evt && serial_mode;
            req_r.wr <= wr_evt && serial_mode;
            req_r.addr <= rd_evt ? rd_addr_x_r : wr_addr_x_r; // R13
            req_r.wdata <= wr_data_x_r;
        end
    end

    assign reg_req = req_r;

    // answer word is held until the next read; the register file answers
    // in the strobe cycle, so the word is taken at the edge ending it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdata_r <= spirg_pkg::BYTE_RST;
        end else if (req_r.rd) begin
            rdata_r <= reg_rd_data;
        end
    end

    // the toggle flips at the same edge as the word; the link side sees it
    // two of its own edges later, by when rdata_r has long settled
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ack_tgl_r <= 1'b0;
        end else if (req_r.rd) begin
            ack_tgl_r <= ~ack_tgl_r;
        end
    end

    // ****************************************************************
    // system domain: management mode strap
    // ****************************************************************

    logic [1:0] strap_s1_r;
    logic [1:0] strap_s2_r;
    logic rst_seen_r;
    spirg_pkg::spirg_mode_type mode_r;

    always_ff @(posedge clk_sys) begin
        strap_s1_r <= mode_strap;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rst_seen_r <= 1'b0;
        end else begin
            rst_seen_r <= 1'b1;
        end
    end

    // the strap passes two flops, so it must settle two clk_sys edges
    // before release to be caught
    // caught once, in the first cycle after release
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            if (!rst_seen_r) begin
                mode_r <= spirg_pkg::spirg_mode_serial;
            end
        end else if (!rst_seen_r) begin
            mode_r <= decode_strap(strap_s2_r); // R12
        end
    end

    assign mgmt_mode = mode_r;

endmodule : spirg_slave

`default_nettype wire

// file: spirg_asserts.sv
// spirg_asserts: port timing checks of the serial register gate.
// assumes binding to spirg_slave; sys and link clocks are unrelated.
`timescale 1ns/100ps
`default_nettype none
module spirg_asserts (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic link_sclk,
    input wire logic chip_select_low,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    input wire logic [1:0] mode_strap,
    input wire spirg_pkg::spirg_mode_type mgmt_mode,
    input wire logic link_busy,
    input wire spirg_pkg::spirg_req_type reg_req,
    input wire logic [7:0] reg_rd_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // six cycles covers the worst sync delay of a late write strobe
    sequence s_idle; chip_select_low [*6]; endsequence
    sequence s_strobe; reg_req.rd || reg_req.wr; endsequence
    property p_oe_sel; serial_data_out_oe |-> !chip_select_low; endproperty
    property p_oe_busy; serial_data_out_oe |-> link_busy; endproperty
    property p_busy_rise;
        $fell(chip_select_low) |-> ##[1:4] link_busy;
    endproperty
    property p_busy_fall; s_idle |-> !link_busy; endproperty
    property p_quiet; s_idle |-> !(reg_req.rd || reg_req.wr); endproperty
    property p_excl; s_strobe |-> !(reg_req.rd && reg_req.wr); endproperty
    property p_wr_pulse; reg_req.wr |=> !reg_req.wr; endproperty
    property p_mode_req;
        s_strobe |-> mgmt_mode == spirg_pkg::spirg_mode_serial;
    endproperty
    property p_mode_hold; $past(reset_n, 2) |-> $stable(mgmt_mode); endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("oe while idle");
    a_oe_busy: assert property (p_oe_busy) else $error("oe not busy");
    a_busy_rise: assert property (p_busy_rise) else $error("no busy");
    a_busy_fall: assert property (p_busy_fall) else $error("busy idle");
    a_quiet: assert property (p_quiet) else $error("strobe idle");
    a_excl: assert property (p_excl) else $error("rd and wr");
    a_wr_pulse: assert property (p_wr_pulse) else $error("long wr");
    a_mode_req: assert property (p_mode_req) else $error("bad mode");
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
endmodule : spirg_asserts
bind spirg_slave spirg_asserts u_chk (.clk_sys, .reset_n, .link_sclk,
    .chip_select_low, .serial_data_in, .serial_data_out, .serial_data_out_oe,
    .mode_strap, .mgmt_mode, .link_busy, .reg_req, .reg_rd_data);
`default_nettype wire

// file: spirg_master_model.sv
// spirg_master_model: behavioural serial master on the link side.
// assumes a 48 ns link clock that stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module spirg_master_model (
    output logic link_sclk,
    output logic chip_select_low,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    localparam int HALF = 24;
    initial begin
        link_sclk = 1'b0;
        chip_select_low = 1'b1;
        serial_data_in = 1'b0;
    end
    // ****************************************************************
    // one frame: header, turnaround, nd data bits, all msb first
    // ****************************************************************
    task automatic xfer(input logic [2:0] cmd, input logic [23:0] adr,
            input int nd, input logic [7:0] wd [4],
            output logic [7:0] rd [4], output logic oe_bad);
        logic [26:0] hdr;
        logic b;
        logic oe;
        hdr = {cmd, adr};
        oe_bad = 1'b0;
        chip_select_low = 1'b0;
        for (int i = 0; i < 32 + nd; i++) begin
            if (i < 27) b = hdr[26 - i];
            else if (i < 32) b = i[0];
            else b = wd[(i - 32) / 8][7 - (i - 32) % 8];
            serial_data_in = b;
            #HALF;
            // read just before the rise: output moved at the fall
            if (i >= 32) rd[(i - 32) / 8][7 - (i - 32) % 8] = serial_data_out;
            oe = serial_data_out_oe;
            if (oe !== (i >= 32 && cmd == spirg_pkg::CMD_READ)) oe_bad = 1'b1;
            link_sclk = 1'b1;
            #HALF;
            link_sclk = 1'b0;
        end
        #HALF;
        chip_select_low = 1'b1;
        serial_data_in = ~serial_data_in;
        #(4 * HALF);
    endtask : xfer
endmodule : spirg_master_model
`default_nettype wire

// file: tb_spi_slave_register_access.sv
// tb_spi_slave_register_access: self-checking bench of the serial gate.
// assumes spirg_master_model on the link and a byte array as register file.
`timescale 1ns/100ps
`default_nettype none
module tb_spi_slave_register_access;
    logic clk_sys = 1'b0;
    // starts unknown: the first drive low must be a falling edge, or the
    // link-side toggles never clear and every crossing stays unknown
    logic reset_n;
    logic [1:0] mode_strap = 2'h0;
    logic link_sclk, chip_select_low, serial_data_in;
    logic serial_data_out, serial_data_out_oe, link_busy;
    spirg_pkg::spirg_mode_type mgmt_mode;
    spirg_pkg::spirg_req_type reg_req;
    logic [7:0] reg_rd_data;
    logic [7:0] regs [65536];
    logic [7:0] wd [4];
    logic [7:0] rd [4];
    logic oe_bad;
    int n_errors = 0;
    int checks_done = 0;
    int n_wr = 0;
    int n_rd = 0;
    always #20 clk_sys = ~clk_sys;
    spirg_slave uut (.clk_sys, .reset_n, .link_sclk, .chip_select_low,
        .serial_data_in, .serial_data_out, .serial_data_out_oe, .mode_strap,
        .mgmt_mode, .link_busy, .reg_req, .reg_rd_data);
    spirg_master_model mm (.link_sclk, .chip_select_low, .serial_data_in,
        .serial_data_out, .serial_data_out_oe);
    // ****************************************************************
    // register file: answers in the strobe cycle
    // ****************************************************************
    assign reg_rd_data = regs[reg_req.addr];
    always @(posedge clk_sys) begin
        if (reg_req.wr === 1'b1) regs[reg_req.addr] <= reg_req.wdata;
        if (reg_req.wr === 1'b1) n_wr <= n_wr + 1;
        if (reg_req.rd === 1'b1) n_rd <= n_rd + 1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic do_reset(input logic [1:0] s);
        @(posedge clk_sys) #1;
        reset_n = 1'b0;
        mode_strap = s;
        repeat (5) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset
    task automatic run(input logic [2:0] c, input logic [23:0] a, input int n);
        @(posedge clk_sys) #1;
        mm.xfer(c, a, n, wd, rd, oe_bad);
        repeat (8) @(posedge clk_sys);
    endtask : run
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_mode;
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            chk(16'(mgmt_mode), (s > 1) ? 16'h2 : 16'(s));
        end
        do_reset(2'h0);
    endtask : t_mode
    task automatic t_write;
        int w0;
        w0 = n_wr;
        wd = '{8'hA5, 8'h3C, 8'h81, 8'h00};
        run(spirg_pkg::CMD_WRITE, 24'h5A12FE, 24);
        chk(16'(n_wr - w0), 16'h3);
        for (int k = 0; k < 3; k++) chk(regs[16'h12FE + k], wd[k]);
        chk(oe_bad, 1'b0);
    endtask : t_write
    task automatic t_read;
        run(spirg_pkg::CMD_READ, 24'hC312FE, 24);
        for (int k = 0; k < 3; k++) chk(rd[k], wd[k]);
        chk(oe_bad, 1'b0);
    endtask : t_read
    task automatic t_abort;
        int w0;
        w0 = n_wr;
        wd[0] = 8'h5E;
        run(spirg_pkg::CMD_WRITE, 24'h000040, 12);
        chk(16'(n_wr - w0), 16'h1);
        chk(regs[16'h0040], 8'h5E);
        chk(regs[16'h0041], 8'h00);
    endtask : t_abort
    task automatic t_badcmd;
        int w0;
        for (int c = 0; c < 8; c++) begin
            if (c == 2 || c == 3) continue;
            w0 = n_wr + n_rd;
            run(c[2:0], 24'h000050, 8);
            chk(16'(n_wr + n_rd - w0), 16'h0);
            chk(oe_bad, 1'b0);
        end
    endtask : t_badcmd
    task automatic t_other_mode;
        int w0;
        do_reset(2'h1);
        w0 = n_wr;
        run(spirg_pkg::CMD_WRITE, 24'h000060, 8);
        chk(16'(n_wr - w0), 16'h0);
        do_reset(2'h0);
    endtask : t_other_mode
    initial begin
        for (int i = 0; i < 65536; i++) regs[i] = 8'h00;
        do_reset(2'h0);
        t_mode();
        t_write();
        t_read();
        t_abort();
        t_badcmd();
        t_other_mode();
        conclude();
    end
    // hang guard: a run that outlives this bound is a failure
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        conclude();
    end
endmodule : tb_spi_slave_register_access
`default_nettype wire
